/* File: core/tsa_aux.sv */
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
// ==================================================================
// How it works
// - ctl bit 0 gates target 0 output event
// - ctl bit 1 lets target 1 change level
// - ctl bit 2 drives clock 0 on fn 10b
// - ctl bit 5 drives clock 1 on fn 11b
// - bit 3 snapshots time to stamp 0, self-clears
// - bit 6 snapshots time to stamp 1, self-clears
// - bit 8 captures stamp 0 on pin change
// - bit 10 captures stamp 1 on pin change
// - bit 9 taken flag, read clears
// - bit 11 taken flag, read clears
// - bit 17 picks toggle or start/end pulse
// - target output on pins with fn 00b
// - bit 31 resets high, freezes system time
// - target ns bits 31:30 zero, all reset zero
// - target 0 seconds compared with nanoseconds
// - target 1 ns bits 31:30 read zero
// - target 1 seconds word is 32 bits
// - running counter steps 8 ns plus fraction
// - stamp seconds read releases the stamp pair
module tsa_aux
	import tsa_pkg::*;
#(
	parameter int PINS = 4
)(
	input  logic              mclk,
	input  logic              rstn,
	input  logic [15:0]       avs_address,
	input  logic              avs_read,
	input  logic              avs_write,
	input  logic [31:0]       avs_writedata,
	input  logic [3:0]        avs_byteenable,
	output logic [31:0]       avs_readdata,
	output logic              avs_waitrequest,
	input  logic [PINS-1:0]   soft_pin_in,
	output logic [PINS-1:0]   soft_pin_out,
	output logic [PINS-1:0]   soft_pin_oe
);

	typedef struct packed {
		tsa_bus_e              bus;
		logic [31:0]           rdata;
		logic [31:0]           ctl;
		logic [1:0][29:0]      tt_ns;
		logic [1:0][31:0]      tt_sec;
		logic [1:0]            tt_done;
		logic                  level;
		logic [1:0][29:0]      half;
		logic [1:0][29:0]      acc;
		logic [1:0]            fclk;
		logic [1:0][29:0]      st_ns;
		logic [1:0][31:0]      st_sec;
		logic [31:0]           pa;
		logic [PINS-1:0]       pin_meta;
		logic [PINS-1:0]       pin_sync;
		logic [PINS-1:0]       pin_prev;
		logic [PINS-1:0]       pin_out;
		logic [PINS-1:0]       pin_oe;
	} tsa_aux_s;

	tsa_aux_s    s_ff;
	tsa_aux_s    nxt_s;
	logic [29:0] sys_ns;
	logic [31:0] sys_sec;
	logic [31:0] sys_res;
	logic [31:0] sys_inc;
	logic        acc_go;
	logic        wr_go;
	logic        rd_go;
	logic [31:0] rd_mux;
	logic [31:0] wd;
	logic [1:0]  fire;
	logic [1:0]  cap;
	logic [1:0]  chg;
	logic [1:0]  rd_rel;
	logic [1:0]  fn;
	logic        pin_drv;
	logic        wr_sys_ns;
	logic        wr_sys_sec;
	logic        wr_sys_res;
	logic        wr_sys_inc;

	// ==================================================================
	// helpers
	function automatic logic [31:0] merge_be(
		input logic [31:0] cur,
		input logic [31:0] wdat,
		input logic [3:0]  be
	);
		logic [31:0] r;
		r = cur;
		for (int b = 0; b < 4; b++) begin
			if (be[b])
				r[8*b +: 8] = wdat[8*b +: 8];
		end
		return r;
	endfunction : merge_be

	function automatic logic time_reached(
		input logic [31:0] sec,
		input logic [29:0] ns,
		input logic [31:0] tsec,
		input logic [29:0] tns
	);
		return {sec, ns} >= {tsec, tns};
	endfunction : time_reached

	function automatic logic is_wr(input logic [15:0] ofs);
		return wr_go && (avs_address == ofs);
	endfunction : is_wr

	// ==================================================================
	// system time counter
	// plain nets: a port expression calling is_wr misses bus changes
	assign wr_sys_ns  = wr_go && (avs_address == OFS_SYS_NS);
	assign wr_sys_sec = wr_go && (avs_address == OFS_SYS_SEC);
	assign wr_sys_res = wr_go && (avs_address == OFS_SYS_RES);
	assign wr_sys_inc = wr_go && (avs_address == OFS_SYS_INC);

	tsa_systime u_systime (
		.mclk    (mclk),
		.rstn    (rstn),
		.run     (!s_ff.ctl[CTL_FREEZE]),
		.wr_ns   (wr_sys_ns),
		.wr_sec  (wr_sys_sec),
		.wr_res  (wr_sys_res),
		.wr_inc  (wr_sys_inc),
		.wdata   (wd),
		.sys_ns  (sys_ns),
		.sys_sec (sys_sec),
		.sys_res (sys_res),
		.sys_inc (sys_inc)
	);

	// ==================================================================
	// bus slave: one wait cycle, then a one-cycle answer
	assign acc_go          = (s_ff.bus == BUS_ACK);
	assign wr_go           = acc_go && avs_write;
	assign rd_go           = acc_go && avs_read;
	assign avs_waitrequest = (avs_read || avs_write) && !acc_go;
	assign avs_readdata    = s_ff.rdata;
	assign soft_pin_out    = s_ff.pin_out;
	assign soft_pin_oe     = s_ff.pin_oe;

	always_comb begin
		case (avs_address)
			OFS_SYS_NS:   rd_mux = {2'b00, sys_ns};
			OFS_SYS_SEC:  rd_mux = sys_sec;
			OFS_SYS_INC:  rd_mux = sys_inc;
			OFS_SYS_RES:  rd_mux = sys_res;
			OFS_CTL:      rd_mux = s_ff.ctl;
			OFS_TT0_NS:   rd_mux = {2'b00, s_ff.tt_ns[0]};
			OFS_TT0_SEC:  rd_mux = s_ff.tt_sec[0];
			OFS_TT1_NS:   rd_mux = {2'b00, s_ff.tt_ns[1]};
			OFS_TT1_SEC:  rd_mux = s_ff.tt_sec[1];
			OFS_HALF0:    rd_mux = {2'b00, s_ff.half[0]};
			OFS_HALF1:    rd_mux = {2'b00, s_ff.half[1]};
			OFS_AUX0_NS:  rd_mux = {2'b00, s_ff.st_ns[0]};
			OFS_AUX0_SEC: rd_mux = s_ff.st_sec[0];
			OFS_AUX1_NS:  rd_mux = {2'b00, s_ff.st_ns[1]};
			OFS_AUX1_SEC: rd_mux = s_ff.st_sec[1];
			OFS_PIN_ASSN: rd_mux = s_ff.pa;
			default:      rd_mux = 32'h0000_0000;
		endcase
	end

	assign wd = merge_be(rd_mux, avs_writedata, avs_byteenable);

	// ==================================================================
	// next state
	always_comb begin
		nxt_s   = s_ff;
		fire    = 2'b00;
		cap     = 2'b00;
		chg     = 2'b00;
		rd_rel  = 2'b00;
		fn      = FN_UNUSED;
		pin_drv = 1'b0;

		nxt_s.pin_meta = soft_pin_in;
		nxt_s.pin_sync = s_ff.pin_meta;
		nxt_s.pin_prev = s_ff.pin_sync;

		case (s_ff.bus)
			BUS_IDLE: begin
				if (avs_read || avs_write) begin
					nxt_s.bus   = BUS_ACK;
					nxt_s.rdata = rd_mux;
				end
			end
			BUS_ACK: begin
				nxt_s.bus = BUS_IDLE;
			end
			default: begin
				nxt_s.bus = BUS_IDLE;
			end
		endcase

		// sample requests clear once served
		if (s_ff.ctl[CTL_SAMPLE0])
			nxt_s.ctl[CTL_SAMPLE0] = 1'b0;
		if (s_ff.ctl[CTL_SAMPLE1])
			nxt_s.ctl[CTL_SAMPLE1] = 1'b0;

		// reserved and status bits keep hardware values
		if (is_wr(OFS_CTL))
			nxt_s.ctl = (nxt_s.ctl & ~CTL_WR_MASK) | (wd & CTL_WR_MASK);
		if (is_wr(OFS_TT0_NS))
			nxt_s.tt_ns[0] = wd[29:0];
		if (is_wr(OFS_TT0_SEC))
			nxt_s.tt_sec[0] = wd;
		if (is_wr(OFS_TT1_NS))
			nxt_s.tt_ns[1] = wd[29:0];
		if (is_wr(OFS_TT1_SEC))
			nxt_s.tt_sec[1] = wd;
		if (is_wr(OFS_HALF0))
			nxt_s.half[0] = wd[29:0];
		if (is_wr(OFS_HALF1))
			nxt_s.half[1] = wd[29:0];
		if (is_wr(OFS_PIN_ASSN))
			nxt_s.pa = wd & SPA_WR_MASK;

		// target compare, once per arming
		for (int t = 0; t < 2; t++) begin
			fire[t] = s_ff.ctl[CTL_TT0_EN + t] && !s_ff.tt_done[t] &&
				time_reached(sys_sec, sys_ns, s_ff.tt_sec[t],
					s_ff.tt_ns[t]);
			if (fire[t])
				nxt_s.tt_done[t] = 1'b1;
			// rewriting the target or dropping enable rearms it
			if (!s_ff.ctl[CTL_TT0_EN + t])
				nxt_s.tt_done[t] = 1'b0;
		end
		if (is_wr(OFS_TT0_NS) || is_wr(OFS_TT0_SEC))
			nxt_s.tt_done[0] = 1'b0;
		if (is_wr(OFS_TT1_NS) || is_wr(OFS_TT1_SEC))
			nxt_s.tt_done[1] = 1'b0;

		if (s_ff.ctl[CTL_PULSE]) begin
			if (fire[1])
				nxt_s.level = 1'b0;
			if (fire[0])
				nxt_s.level = 1'b1;
		end else begin
			nxt_s.level = s_ff.level ^ fire[0] ^ fire[1];
		end

		// auxiliary captures
		chg[0] = s_ff.pin_sync[s_ff.pa[SPA_CAP0_SEL +: 2]] ^
			s_ff.pin_prev[s_ff.pa[SPA_CAP0_SEL +: 2]];
		chg[1] = s_ff.pin_sync[s_ff.pa[SPA_CAP1_SEL +: 2]] ^
			s_ff.pin_prev[s_ff.pa[SPA_CAP1_SEL +: 2]];
		rd_rel[0] = rd_go && (avs_address == OFS_AUX0_SEC);
		rd_rel[1] = rd_go && (avs_address == OFS_AUX1_SEC);
		cap[0] = s_ff.ctl[CTL_SAMPLE0] ||
			(s_ff.ctl[CTL_PCAP0_EN] && s_ff.pa[SPA_CAP0_EN] &&
			chg[0] && !s_ff.ctl[CTL_TAKEN0]);
		cap[1] = s_ff.ctl[CTL_SAMPLE1] ||
			(s_ff.ctl[CTL_PCAP1_EN] && s_ff.pa[SPA_CAP1_EN] &&
			chg[1] && !s_ff.ctl[CTL_TAKEN1]);
		for (int c = 0; c < 2; c++) begin
			if (cap[c]) begin
				nxt_s.st_ns[c]  = sys_ns;
				nxt_s.st_sec[c] = sys_sec;
			end
		end
		// a capture in the releasing cycle keeps the flag up
		nxt_s.ctl[CTL_TAKEN0] = (s_ff.ctl[CTL_TAKEN0] && !rd_rel[0]) ||
			cap[0];
		nxt_s.ctl[CTL_TAKEN1] = (s_ff.ctl[CTL_TAKEN1] && !rd_rel[1]) ||
			cap[1];

		// frequency clocks count SYS_STEP_NS per cycle, even while system time is frozen
		for (int k = 0; k < 2; k++) begin
			if (!s_ff.ctl[k == 0 ? CTL_CLK0_EN : CTL_CLK1_EN]) begin
				nxt_s.acc[k]  = 30'h0;
				nxt_s.fclk[k] = 1'b0;
			end else if ({1'b0, s_ff.acc[k]} + SYS_STEP_NS >=
					{1'b0, s_ff.half[k]}) begin
				nxt_s.acc[k]  = 30'h0;
				nxt_s.fclk[k] = !s_ff.fclk[k];
			end else begin
				nxt_s.acc[k] = s_ff.acc[k] + SYS_STEP_NS[29:0];
			end
		end

		// pin drive; undefined function code leaves the pin an input
		for (int p = 0; p < PINS; p++) begin
			fn = s_ff.pa[SPA_FN_LSB + SPA_FN_STEP*p +: 2];
			pin_drv = s_ff.pa[SPA_FN_LSB + SPA_FN_STEP*p + SPA_FN_EN];
			case (fn)
				FN_TARGET: nxt_s.pin_out[p] = pin_drv && s_ff.level;
				FN_CLK0:   nxt_s.pin_out[p] = pin_drv && s_ff.fclk[0];
				FN_CLK1:   nxt_s.pin_out[p] = pin_drv && s_ff.fclk[1];
				default:   nxt_s.pin_out[p] = 1'b0;
			endcase
			nxt_s.pin_oe[p] = pin_drv && (fn != FN_UNUSED);
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s_ff     <= '0;
			s_ff.bus <= BUS_IDLE;
			s_ff.ctl <= CTL_RESET;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ==================================================================
	// checks
	AST_TT_QUIET: assert property (@(posedge mclk) disable iff (!rstn)
		(!s_ff.ctl[CTL_TT0_EN] && !s_ff.ctl[CTL_TT1_EN]) |=>
			(s_ff.level == $past(s_ff.level)))
		else $error("target level moved with targets off");

	AST_PULSE_START: assert property (@(posedge mclk) disable iff (!rstn)
		(fire[0] && s_ff.ctl[CTL_PULSE]) |=> s_ff.level)
		else $error("pulse did not start at target 0");

	AST_TT1_TOGGLE: assert property (@(posedge mclk) disable iff (!rstn)
		(fire[1] && !fire[0] && !s_ff.ctl[CTL_PULSE]) |=>
			(s_ff.level != $past(s_ff.level)))
		else $error("target 1 did not change level");

	AST_FIRE_ONCE: assert property (@(posedge mclk) disable iff (!rstn)
		(fire[0] && !is_wr(OFS_TT0_NS) && !is_wr(OFS_TT0_SEC)) |=>
			!fire[0])
		else $error("target 0 fired twice");

	AST_CLK0_OFF: assert property (@(posedge mclk) disable iff (!rstn)
		!s_ff.ctl[CTL_CLK0_EN] |=> !s_ff.fclk[0])
		else $error("clock 0 running while disabled");

	AST_CLK1_OFF: assert property (@(posedge mclk) disable iff (!rstn)
		!s_ff.ctl[CTL_CLK1_EN] |=> !s_ff.fclk[1])
		else $error("clock 1 running while disabled");

	AST_SAMPLE0: assert property (@(posedge mclk) disable iff (!rstn)
		s_ff.ctl[CTL_SAMPLE0] |=> (s_ff.st_ns[0] == $past(sys_ns) &&
			s_ff.st_sec[0] == $past(sys_sec) && s_ff.ctl[CTL_TAKEN0]))
		else $error("sample request 0 not served");

	AST_SAMPLE1: assert property (@(posedge mclk) disable iff (!rstn)
		s_ff.ctl[CTL_SAMPLE1] |=> (s_ff.st_ns[1] == $past(sys_ns) &&
			s_ff.ctl[CTL_TAKEN1]))
		else $error("sample request 1 not served");

	AST_TAKEN0_CLR: assert property (@(posedge mclk) disable iff (!rstn)
		(rd_rel[0] && !cap[0]) |=> !s_ff.ctl[CTL_TAKEN0])
		else $error("taken 0 not cleared by read");

	AST_TAKEN1_CLR: assert property (@(posedge mclk) disable iff (!rstn)
		(rd_rel[1] && !cap[1]) |=> !s_ff.ctl[CTL_TAKEN1])
		else $error("taken 1 not cleared by read");

	AST_HOLD0: assert property (@(posedge mclk) disable iff (!rstn)
		(s_ff.ctl[CTL_TAKEN0] && !s_ff.ctl[CTL_SAMPLE0]) |=>
			$stable(s_ff.st_sec[0]))
		else $error("held stamp 0 overwritten");

	AST_PIN_TT: assert property (@(posedge mclk) disable iff (!rstn)
		(s_ff.pa[10:8] == 3'b100) |=>
			(soft_pin_oe[0] && soft_pin_out[0] == $past(s_ff.level)))
		else $error("pin 0 not driving target level");

	AST_NS_TOP: assert property (@(posedge mclk) disable iff (!rstn)
		(avs_read && !acc_go && avs_address == OFS_TT0_NS) |=>
			(avs_readdata[31:30] == 2'b00 && !avs_waitrequest))
		else $error("target ns high bits not zero");

endmodule : tsa_aux

/* File: core/tsa_systime.sv */
`timescale 1ns/1ps
module tsa_systime
	import tsa_pkg::*;
(
	input  logic        mclk,
	input  logic        rstn,
	input  logic        run,
	input  logic        wr_ns,
	input  logic        wr_sec,
	input  logic        wr_res,
	input  logic        wr_inc,
	input  logic [31:0] wdata,
	output logic [29:0] sys_ns,
	output logic [31:0] sys_sec,
	output logic [31:0] sys_res,
	output logic [31:0] sys_inc
);

	typedef struct packed {
		logic [29:0] ns;
		logic [31:0] sec;
		logic [31:0] res;
		logic [31:0] inc;
	} tsa_st_s;

	tsa_st_s     s_ff;
	tsa_st_s     nxt_s;
	logic [32:0] frac;
	logic [30:0] ns_t;

	// ==================================================================
	// counter
	always_comb begin
		nxt_s = s_ff;
		frac  = 33'h0_0000_0000;
		ns_t  = {1'b0, s_ff.ns};
		if (run) begin
			if (!s_ff.inc[INC_SIGN]) begin
				frac = {1'b0, s_ff.res} + {2'b00, s_ff.inc[30:0]};
				ns_t = ns_t + SYS_STEP_NS + {30'h0, frac[32]};
			end else begin
				frac = {1'b0, s_ff.res} - {2'b00, s_ff.inc[30:0]};
				ns_t = ns_t + SYS_STEP_NS - {30'h0, frac[32]};
			end
			nxt_s.res = frac[31:0];
			// one step never passes two seconds, so one wrap is enough
			if (ns_t >= NS_PER_SEC) begin
				ns_t       = ns_t - NS_PER_SEC;
				nxt_s.sec  = s_ff.sec + 32'h0000_0001;
			end
			nxt_s.ns = ns_t[29:0];
		end
		// software writes land even while frozen
		if (wr_ns)
			nxt_s.ns = wdata[29:0];
		if (wr_sec)
			nxt_s.sec = wdata;
		if (wr_res)
			nxt_s.res = wdata;
		if (wr_inc)
			nxt_s.inc = wdata;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end

	assign sys_ns  = s_ff.ns;
	assign sys_sec = s_ff.sec;
	assign sys_res = s_ff.res;
	assign sys_inc = s_ff.inc;

	AST_FROZEN: assert property (@(posedge mclk) disable iff (!rstn)
		(!run && !wr_ns && !wr_sec && !wr_res) |=>
			($stable(sys_ns) && $stable(sys_sec) && $stable(sys_res)))
		else $error("system time moved while frozen");

	AST_ADVANCE: assert property (@(posedge mclk) disable iff (!rstn)
		(run && !wr_ns && !wr_sec && s_ff.inc == 32'h0 &&
			s_ff.ns < 30'h3B9A_C618) |=>
			(sys_ns == $past(sys_ns) + 30'h0000_0008))
		else $error("system time did not advance by one step");

endmodule : tsa_systime

/* File: pkg/tsa_pkg.sv */
package tsa_pkg;

	// ==================================================================
	// register byte addresses
	localparam int          ADDR_W        = 16;
	localparam logic [15:0] OFS_SYS_NS    = 16'hB600;
	localparam logic [15:0] OFS_SYS_SEC   = 16'hB604;
	localparam logic [15:0] OFS_SYS_INC   = 16'hB608;
	localparam logic [15:0] OFS_SYS_RES   = 16'hB6F8;
	localparam logic [15:0] OFS_CTL       = 16'hB640;
	localparam logic [15:0] OFS_TT0_NS    = 16'hB644;
	localparam logic [15:0] OFS_TT0_SEC   = 16'hB648;
	localparam logic [15:0] OFS_TT1_NS    = 16'hB64C;
	localparam logic [15:0] OFS_TT1_SEC   = 16'hB650;
	localparam logic [15:0] OFS_HALF0     = 16'hB654;
	localparam logic [15:0] OFS_HALF1     = 16'hB658;
	localparam logic [15:0] OFS_AUX0_NS   = 16'hB65C;
	localparam logic [15:0] OFS_AUX0_SEC  = 16'hB660;
	localparam logic [15:0] OFS_AUX1_NS   = 16'hB664;
	localparam logic [15:0] OFS_AUX1_SEC  = 16'hB668;
	localparam logic [15:0] OFS_PIN_ASSN  = 16'h003C;

	// ==================================================================
	// time_aux_control fields
	localparam int CTL_TT0_EN   = 0;
	localparam int CTL_TT1_EN   = 1;
	localparam int CTL_CLK0_EN  = 2;
	localparam int CTL_SAMPLE0  = 3;
	localparam int CTL_CLK1_EN  = 5;
	localparam int CTL_SAMPLE1  = 6;
	localparam int CTL_PCAP0_EN = 8;
	localparam int CTL_TAKEN0   = 9;
	localparam int CTL_PCAP1_EN = 10;
	localparam int CTL_TAKEN1   = 11;
	localparam int CTL_PULSE    = 17;
	localparam int CTL_FREEZE   = 31;
	localparam logic [31:0] CTL_RESET   = 32'h8000_0000;
	localparam logic [31:0] CTL_WR_MASK = 32'h8002_056F;

	// ==================================================================
	// soft_pin_assign fields
	localparam int SPA_CAP0_SEL = 0;
	localparam int SPA_CAP0_EN  = 2;
	localparam int SPA_CAP1_SEL = 3;
	localparam int SPA_CAP1_EN  = 5;
	localparam int SPA_FN_LSB   = 8;
	localparam int SPA_FN_STEP  = 3;
	localparam int SPA_FN_EN    = 2;
	localparam logic [31:0] SPA_WR_MASK = 32'h000F_FFFF;
	localparam logic [1:0]  FN_TARGET   = 2'h0;
	localparam logic [1:0]  FN_UNUSED   = 2'h1;
	localparam logic [1:0]  FN_CLK0     = 2'h2;
	localparam logic [1:0]  FN_CLK1     = 2'h3;

	// ==================================================================
	// time values
	localparam logic [31:0] NS_MASK     = 32'h3FFF_FFFF;
	localparam logic [30:0] NS_PER_SEC  = 31'h3B9A_CA00;
	localparam logic [30:0] SYS_STEP_NS = 31'h0000_0008;
	localparam int          INC_SIGN    = 31;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK  = 2'b10
	} tsa_bus_e;

endpackage : tsa_pkg

/* File: verif/tsa_aux_tb.sv */
`timescale 1ns/1ps
module tsa_aux_tb;
	import tsa_pkg::*;
	logic        mclk, rstn, avs_read, avs_write, avs_waitrequest;
	logic [15:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, a, b;
	logic [3:0]  avs_byteenable, pin_in, pin_out, pin_oe, ext_oe, ext_val;
	int          errors, samples_checked, ch, t2, t3;

	tsa_aux #(.PINS(4)) DUT (
		.mclk(mclk), .rstn(rstn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.soft_pin_in(pin_in), .soft_pin_out(pin_out), .soft_pin_oe(pin_oe));
	tsa_pin_model #(.PINS(4)) far_side (
		.pin_out(pin_out), .pin_oe(pin_oe), .ext_oe(ext_oe),
		.ext_val(ext_val), .pin_in(pin_in));

	// ==================================================================
	// closing and checks
	task automatic report_and_stop();
		if (errors == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : report_and_stop
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t word got %h exp %h", $time, got, exp);
		end
	endtask : chk_word
	task automatic chk_count(input int got, input int lo, input int hi);
		samples_checked++;
		if (got < lo || got > hi) begin
			errors++;
			$display("[FAIL] %0t edge count %0d not in %0d..%0d", $time,
				got, lo, hi);
		end
	endtask : chk_count

	// ==================================================================
	// avalon master: hold until waitrequest sampled low at a rising edge
	task automatic bus(input logic w, input logic [15:0] ad,
		input logic [31:0] d, input logic [3:0] be, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge mclk);
		avs_address    <= ad;
		avs_writedata  <= d;
		avs_byteenable <= be;
		avs_read       <= !w;
		avs_write      <= w;
		// answer and read data are taken at the very edge they stand at
		do begin
			@(posedge mclk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50) begin
			errors++;
			$display("[FAIL] %0t no bus answer", $time);
		end
		q = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task automatic wr(input logic [15:0] ad, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, ad, d, 4'hF, q);
	endtask : wr
	task automatic rd(input logic [15:0] ad, output logic [31:0] q);
		bus(1'b0, ad, 32'h0, 4'hF, q);
	endtask : rd
	task automatic rdchk(input logic [15:0] ad, input logic [31:0] e);
		logic [31:0] q;
		rd(ad, q);
		chk_word(q, e);
	endtask : rdchk
	// only legal while the counter is frozen
	task automatic set_time(input logic [31:0] s, input logic [31:0] n);
		wr(OFS_SYS_NS, n);
		wr(OFS_SYS_SEC, s);
	endtask : set_time
	task automatic pin_flip();
		@(posedge mclk);
		ext_val <= ext_val ^ 4'h6;
		repeat (8) @(posedge mclk);
	endtask : pin_flip
	task automatic toggles(input int cyc, output int c2, output int c3);
		logic [3:0] p;
		c2 = 0;
		c3 = 0;
		@(negedge mclk);
		p = pin_out;
		repeat (cyc) begin
			@(negedge mclk);
			c2 += (pin_out[2] !== p[2]);
			c3 += (pin_out[3] !== p[3]);
			p = pin_out;
		end
	endtask : toggles

	// ==================================================================
	// clock, reset, watchdog
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	initial begin
		repeat (20000) @(posedge mclk);
		errors++;
		$display("[FAIL] %0t run did not finish", $time);
		report_and_stop();
	end

	// ==================================================================
	// tests; every control write keeps reserved bits zero
	initial begin
		errors = 0;
		samples_checked = 0;
		rstn = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 16'h0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hF;
		ext_oe = 4'h6;
		ext_val = 4'h0;
		repeat (3) @(posedge mclk);
		rstn <= 1'b1;
		rdchk(OFS_CTL, CTL_RESET);
		rdchk(OFS_TT0_NS, 32'h0);
		rdchk(OFS_TT0_SEC, 32'h0);
		rdchk(OFS_TT1_NS, 32'h0);
		wr(OFS_TT0_NS, 32'hFFFF_FFFF);
		rdchk(OFS_TT0_NS, 32'h3FFF_FFFF);
		wr(OFS_TT1_NS, 32'hFFFF_FFFF);
		rdchk(OFS_TT1_NS, 32'h3FFF_FFFF);
		wr(OFS_TT0_SEC, 32'hFFFF_FFFF);
		bus(1'b1, OFS_TT0_SEC, 32'h0000_00AA, 4'h1, a);
		rdchk(OFS_TT0_SEC, 32'hFFFF_FFAA);
		wr(OFS_TT1_SEC, 32'hFFFF_FFFF);
		rdchk(OFS_TT1_SEC, 32'hFFFF_FFFF);
		rdchk(16'h1000, 32'h0);
		// frozen counter holds, running counter steps 8 ns a cycle
		set_time(32'h3, 32'h3E8);
		repeat (5) @(posedge mclk);
		rdchk(OFS_SYS_NS, 32'h3E8);
		wr(OFS_CTL, 32'h0);
		rd(OFS_SYS_NS, a);
		rd(OFS_SYS_NS, b);
		chk_word(b - a, 32'h18);
		// software snapshot on both channels
		for (ch = 0; ch < 2; ch++) begin
			wr(OFS_CTL, 32'h8000_0000);
			set_time(32'hA + ch, 32'h1F4 + ch);
			wr(OFS_CTL, 32'h8000_0000 | (32'h8 << (3 * ch)));
			rdchk(OFS_CTL, 32'h8000_0000 | (32'h200 << (2 * ch)));
			rdchk(ch ? OFS_AUX1_NS : OFS_AUX0_NS, 32'h1F4 + ch);
			rdchk(ch ? OFS_AUX1_SEC : OFS_AUX0_SEC, 32'hA + ch);
			rdchk(OFS_CTL, 32'h8000_0000);
		end
		// pin capture: pin 1 to stamp 0, pin 2 to stamp 1
		wr(OFS_PIN_ASSN, 32'h0000_0035);
		wr(OFS_CTL, 32'h8000_0500);
		set_time(32'h14, 32'h28);
		pin_flip();
		rdchk(OFS_CTL, 32'h8000_0F00);
		set_time(32'h15, 32'h50);
		pin_flip();
		rdchk(OFS_AUX0_NS, 32'h28);
		rdchk(OFS_AUX0_SEC, 32'h14);
		rdchk(OFS_AUX1_NS, 32'h28);
		rdchk(OFS_AUX1_SEC, 32'h14);
		rdchk(OFS_CTL, 32'h8000_0500);
		pin_flip();
		rdchk(OFS_AUX0_SEC, 32'h15);
		rdchk(OFS_AUX1_SEC, 32'h15);
		// pulse mode: pin 0 carries target output, pin 3 unused
		wr(OFS_PIN_ASSN, 32'h000A_0400);
		wr(OFS_CTL, 32'h8000_0000);
		set_time(32'h6, 32'h0);
		wr(OFS_TT0_NS, 32'h50);
		wr(OFS_TT0_SEC, 32'h6);
		wr(OFS_TT1_NS, 32'h190);
		wr(OFS_TT1_SEC, 32'h6);
		wr(OFS_CTL, 32'h0002_0003);
		repeat (25) @(negedge mclk);
		chk_word({28'h0, pin_oe}, 32'h1);
		chk_word({31'h0, pin_out[0]}, 32'h1);
		repeat (40) @(negedge mclk);
		chk_word({31'h0, pin_out[0]}, 32'h0);
		// toggle mode, first disabled while time passes the target
		wr(OFS_CTL, 32'h8000_0000);
		set_time(32'h7, 32'h0);
		wr(OFS_TT0_NS, 32'hC8);
		wr(OFS_TT0_SEC, 32'h7);
		wr(OFS_CTL, 32'h0);
		repeat (40) @(negedge mclk);
		chk_word({31'h0, pin_out[0]}, 32'h0);
		wr(OFS_CTL, 32'h1);
		repeat (10) @(negedge mclk);
		chk_word({31'h0, pin_out[0]}, 32'h1);
		repeat (40) @(negedge mclk);
		chk_word({31'h0, pin_out[0]}, 32'h1);
		// target 1 already passed: arming it toggles the level back
		wr(OFS_CTL, 32'h3);
		repeat (10) @(negedge mclk);
		chk_word({31'h0, pin_out[0]}, 32'h0);
		// clocks: pin 2 on clock 0, pin 3 on clock 1
		ext_oe <= 4'h0;
		wr(OFS_HALF0, 32'h28);
		wr(OFS_HALF1, 32'h50);
		wr(OFS_PIN_ASSN, 32'h000F_8000);
		wr(OFS_CTL, 32'h24);
		toggles(200, t2, t3);
		chk_count(t2, 39, 41);
		chk_count(t3, 19, 21);
		wr(OFS_CTL, 32'h20);
		repeat (2) @(posedge mclk);
		toggles(100, t2, t3);
		chk_count(t2, 0, 0);
		chk_word({31'h0, pin_out[2]}, 32'h0);
		chk_count(t3, 9, 11);
		report_and_stop();
	end
endmodule : tsa_aux_tb

/* File: verif/tsa_pin_model.sv */
`timescale 1ns/1ps
// ==================================================================
// far side: external circuitry sitting on the soft pins
module tsa_pin_model #(
	parameter int PINS = 4
)(
	input  logic [PINS-1:0] pin_out,
	input  logic [PINS-1:0] pin_oe,
	input  logic [PINS-1:0] ext_oe,
	input  logic [PINS-1:0] ext_val,
	output logic [PINS-1:0] pin_in
);
	// released pins float high on a pull-up, never the last value
	// two drivers at once is contention, so the wire goes unknown
	always_comb begin
		for (int p = 0; p < PINS; p++) begin
			if (pin_oe[p] && ext_oe[p])
				pin_in[p] = 1'bx;
			else if (pin_oe[p])
				pin_in[p] = pin_out[p];
			else if (ext_oe[p])
				pin_in[p] = ext_val[p];
			else
				pin_in[p] = 1'b1;
		end
	end
endmodule : tsa_pin_model
